//--- pbsc_pkg.sv
// Purpose: constants, types and helpers for the PTP buffer and shaper control block
// Assumes: one 50 MHz clock, AXI4-Lite register access, byte lanes little-endian in a word
// Notes: every register is one aligned 32-bit word at its byte address
// Behaviour
// - 2K byte transmit memory, eight 256-byte slots
// - slots zero to six preloaded, all writable
// - slot byte zero gives bytes to send
// - timestamp written to slot top word
// - slot n at 0x11000 plus n*0x100
// - transmit control 18:16 shows last slot
// - pending bit set until frame sent
// - writing request bit queues slot, reads zero
// - transmit done event, cleared by control access
// - receive done event, cleared by control access
// - receive control 11:8 shows last slot
// - flush bit sets write to read pointer
// - drain rate field, reset 2048
// - fill rate field, reset 6144
// - credit shaper gates slot grants
// - receive pointer advances over sixteen slots
package pbsc_pkg;
   // =====================================================================
   // register map
   localparam int PBSC_ADDR_W = 18;
   localparam logic [17:0] PBSC_TX_MEM_BASE = 18'h11000;
   localparam logic [17:0] PBSC_TX_MEM_END = 18'h117fc;
   localparam logic [17:0] PBSC_REG_TX_CTRL = 18'h12000;
   localparam logic [17:0] PBSC_REG_RX_CTRL = 18'h12004;
   localparam logic [17:0] PBSC_REG_DRAIN = 18'h1200c;
   localparam logic [17:0] PBSC_REG_FILL = 18'h12010;
   localparam logic [17:0] PBSC_REG_IRQ_STAT = 18'h12018;
   localparam logic [17:0] PBSC_REG_IRQ_MASK = 18'h1201c;
   // =====================================================================
   // fields and reset values
   localparam int PBSC_TX_REQ_LSB = 0;
   localparam int PBSC_TX_PEND_LSB = 8;
   localparam int PBSC_TX_LAST_LSB = 16;
   localparam int PBSC_RX_LAST_LSB = 8;
   localparam int PBSC_RX_FLUSH_BIT = 0;
   localparam int PBSC_SLOPE_W = 20;
   localparam logic [19:0] PBSC_DRAIN_RST = 20'h00800;
   localparam logic [19:0] PBSC_FILL_RST = 20'h01800;
   localparam int PBSC_IRQ_TX = 0;
   localparam int PBSC_IRQ_RX = 1;
   localparam logic [1:0] PBSC_RESP_OKAY = 2'h0;
   localparam logic [1:0] PBSC_RESP_SLVERR = 2'h2;
   // =====================================================================
   // slot geometry
   localparam int PBSC_SLOT_WORDS = 64;
   localparam logic [7:0] PBSC_FRAME_START = 8'h08;
   localparam logic [5:0] PBSC_STAMP_WORD = 6'h3f;
   localparam int PBSC_PRELOADED = 7;
   // =====================================================================
   // preload contents: dst address, ethertype, message type per slot
   localparam logic [7:0] PBSC_PRELOAD_LEN = 8'h44;
   localparam logic [31:0] PBSC_PRE_DA_LO = 32'h00c28001;
   localparam logic [31:0] PBSC_PRE_DA_HI = 32'h00000e00;
   localparam logic [15:0] PBSC_PRE_ETYPE = 16'hf788;
   localparam logic [7:0] PBSC_PRE_VERSION = 8'h02;
   localparam logic [7:0] PBSC_MSG_TYPE [7] = '{8'h00, 8'h08, 8'h02, 8'h03, 8'h0a, 8'h0b, 8'h0c};

   typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_STAMP} pbsc_tx_state_type;
   typedef enum logic [2:0] {RG_MEM, RG_TXC, RG_RXC, RG_DRAIN, RG_FILL, RG_STAT, RG_MASK,
                             RG_NONE} pbsc_region_type;

   // reset content of one memory word; slot 7 and unlisted words start at zero
   function automatic logic [31:0] pbsc_preload(input int slot, input int word);
      logic [31:0] v;
      v = 32'h0;
      if (slot < PBSC_PRELOADED) begin
         case (word)
            0: v = {24'h0, PBSC_PRELOAD_LEN};
            2: v = PBSC_PRE_DA_LO;
            3: v = PBSC_PRE_DA_HI;
            5: v = {PBSC_PRE_VERSION, PBSC_MSG_TYPE[slot], PBSC_PRE_ETYPE};
            default: v = 32'h0;
         endcase
      end
      return v;
   endfunction

   // address decode, shared by the read and write paths
   function automatic pbsc_region_type pbsc_decode(input logic [17:0] a);
      logic [17:0] w;
      w = {a[17:2], 2'h0};
      if (w >= PBSC_TX_MEM_BASE && w <= PBSC_TX_MEM_END) return RG_MEM;
      else if (w == PBSC_REG_TX_CTRL) return RG_TXC;
      else if (w == PBSC_REG_RX_CTRL) return RG_RXC;
      else if (w == PBSC_REG_DRAIN) return RG_DRAIN;
      else if (w == PBSC_REG_FILL) return RG_FILL;
      else if (w == PBSC_REG_IRQ_STAT) return RG_STAT;
      else if (w == PBSC_REG_IRQ_MASK) return RG_MASK;
      return RG_NONE;
   endfunction

   // byte-lane merge of a write into an existing word
   function automatic logic [31:0] pbsc_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction
endpackage

//--- pbsc_ctrl.sv
// Purpose: AXI4-Lite register bank, PTP transmit slot memory, sender and credit shaper
// Assumes: MAC datapath and receive store share clk_i; timestamp is valid at frame end
// Notes: receive buffer storage itself lives in the receive datapath, only pointers here
`timescale 1ns/1ps
module pbsc_ctrl
   import pbsc_pkg::*;
#(
   parameter int TX_SLOTS = 8,
   parameter int RX_SLOTS = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [17:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [17:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   output logic tx_last_o,
   input wire logic tx_ready_i,
   input wire logic [31:0] tx_stamp_i,
   input wire logic rx_done_i,
   input wire logic [3:0] rx_rd_ptr_i,
   output logic [3:0] rx_wr_ptr_o,
   output logic irq_o
);
   localparam int MEM_WORDS = TX_SLOTS * PBSC_SLOT_WORDS;

   // =====================================================================
   // state
   logic [31:0] mem_q [MEM_WORDS];
   logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
   logic [17:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [7:0] pend_q, pend_d;
   logic [2:0] tx_last_q, slot_q;
   logic [3:0] rx_wr_q, rx_last_q;
   logic [1:0] stat_q, stat_d, mask_q;
   logic [19:0] drain_q, fill_q;
   logic signed [31:0] credit_q, credit_d;
   pbsc_tx_state_type st_q;
   logic [7:0] off_q, rem_q, len_q, tx_data_q;
   logic tx_valid_q;

   // =====================================================================
   // bus decode
   pbsc_region_type wr_rg, rd_rg;
   logic do_write, do_read, tx_hs, grant, any_pend, flush;
   logic [2:0] grant_slot;
   logic [8:0] stamp_idx;
   logic [1:0] stat_set, stat_clr;
   logic [31:0] rd_word, drain_wr, fill_wr;

   assign wr_rg = pbsc_decode(awaddr_q);
   assign rd_rg = pbsc_decode(s_axi_araddr);
   // a write waits one cycle while the timestamp owns the memory write port
   assign do_write = aw_held_q && w_held_q && !bvalid_q && st_q != TX_STAMP;
   assign do_read = s_axi_arvalid && !rvalid_q;
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   // read mux; request bits and flush bit always read as zero
   always_comb begin
      case (rd_rg)
         RG_MEM: rd_word = mem_q[s_axi_araddr[10:2]];
         RG_TXC: rd_word = (32'(tx_last_q) << PBSC_TX_LAST_LSB)
                         | (32'(pend_q) << PBSC_TX_PEND_LSB);
         RG_RXC: rd_word = 32'(rx_last_q) << PBSC_RX_LAST_LSB;
         RG_DRAIN: rd_word = 32'(drain_q);
         RG_FILL: rd_word = 32'(fill_q);
         RG_STAT: rd_word = 32'(stat_q);
         RG_MASK: rd_word = 32'(mask_q);
         default: rd_word = 32'h0;
      endcase
   end

   // =====================================================================
   // AXI4-Lite write and read channels
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         bvalid_q <= 1'b0;
         awaddr_q <= 18'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bresp_q <= PBSC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (wr_rg == RG_NONE) ? PBSC_RESP_SLVERR : PBSC_RESP_OKAY;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= PBSC_RESP_OKAY;
      end else if (do_read) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= (rd_rg == RG_NONE) ? PBSC_RESP_SLVERR : PBSC_RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // =====================================================================
   // transmit slot memory: preload at reset, bus writes, timestamp write-back
   assign stamp_idx = {slot_q, PBSC_STAMP_WORD};
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < MEM_WORDS; i++) begin
            mem_q[i] <= pbsc_preload(i / PBSC_SLOT_WORDS, i % PBSC_SLOT_WORDS);
         end
      end else if (st_q == TX_STAMP) begin
         mem_q[stamp_idx] <= tx_stamp_i;
      end else if (do_write && wr_rg == RG_MEM) begin
         mem_q[awaddr_q[10:2]] <= pbsc_merge(mem_q[awaddr_q[10:2]], wdata_q, wstrb_q);
      end
   end

   // one byte of a slot, little-endian within each word
   function automatic logic [7:0] slot_byte(input logic [2:0] s, input logic [7:0] o);
      logic [31:0] w;
      w = mem_q[{s, o[7:2]}];
      return w[8 * o[1:0] +: 8];
   endfunction

   // =====================================================================
   // slot requests and arbiter; lowest pending slot wins when credit allows
   assign any_pend = |pend_q;
   assign grant = st_q == TX_IDLE && any_pend && !credit_q[31];
   always_comb begin
      grant_slot = 3'h0;
      for (int i = TX_SLOTS - 1; i >= 0; i--) begin
         if (pend_q[i]) grant_slot = 3'(i);
      end
   end

   // set wins over clear, though writes are held off during the stamp cycle anyway
   always_comb begin
      pend_d = pend_q;
      if (st_q == TX_STAMP) pend_d[slot_q] = 1'b0;
      if (do_write && wr_rg == RG_TXC && wstrb_q[0]) begin
         pend_d = pend_d | wdata_q[PBSC_TX_REQ_LSB +: 8];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) pend_q <= 8'h0;
      else pend_q <= pend_d;
   end

   // =====================================================================
   // frame sender: one slot at a time, length byte counts the bytes
   assign tx_hs = tx_valid_q && tx_ready_i;
   assign tx_data_o = tx_data_q;
   assign tx_valid_o = tx_valid_q;
   assign tx_last_o = tx_valid_q && rem_q == 8'h01;
   // software edits to a slot under transmission reach the wire; no shadow copy kept
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= TX_IDLE;
         slot_q <= 3'h0;
         off_q <= 8'h0;
         rem_q <= 8'h0;
         len_q <= 8'h0;
         tx_data_q <= 8'h0;
         tx_valid_q <= 1'b0;
         tx_last_q <= 3'h0;
      end else begin
         case (st_q)
            TX_IDLE: begin
               if (grant) begin
                  slot_q <= grant_slot;
                  len_q <= slot_byte(grant_slot, 8'h00);
                  rem_q <= slot_byte(grant_slot, 8'h00);
                  tx_data_q <= slot_byte(grant_slot, PBSC_FRAME_START);
                  off_q <= PBSC_FRAME_START + 8'h01;
                  tx_valid_q <= slot_byte(grant_slot, 8'h00) != 8'h00;
                  st_q <= (slot_byte(grant_slot, 8'h00) != 8'h00) ? TX_SEND : TX_STAMP;
               end
            end
            TX_SEND: begin
               if (tx_hs) begin
                  if (rem_q == 8'h01) begin
                     tx_valid_q <= 1'b0;
                     st_q <= TX_STAMP;
                  end else begin
                     tx_data_q <= slot_byte(slot_q, off_q);
                     off_q <= off_q + 8'h01;
                  end
                  rem_q <= rem_q - 8'h01;
               end
            end
            TX_STAMP: begin
               tx_last_q <= slot_q;
               st_q <= TX_IDLE;
            end
            default: st_q <= TX_IDLE;
         endcase
      end
   end

   // =====================================================================
   // credit shaper: drain while sending, fill while waiting or in debt
   always_comb begin
      credit_d = credit_q;
      if (st_q == TX_SEND) credit_d = credit_q - signed'(32'(drain_q));
      else if (any_pend || credit_q[31]) credit_d = credit_q + signed'(32'(fill_q));
      else if (credit_q > 0) credit_d = '0;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) credit_q <= '0;
      else credit_q <= credit_d;
   end

   // =====================================================================
   // slope, mask and receive pointer registers
   assign flush = do_write && wr_rg == RG_RXC && wstrb_q[0] && wdata_q[PBSC_RX_FLUSH_BIT];
   assign rx_wr_ptr_o = rx_wr_q;
   // merged words are formed apart so the field cut below is a plain part-select
   assign drain_wr = pbsc_merge(32'(drain_q), wdata_q, wstrb_q);
   assign fill_wr = pbsc_merge(32'(fill_q), wdata_q, wstrb_q);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         drain_q <= PBSC_DRAIN_RST;
         fill_q <= PBSC_FILL_RST;
         mask_q <= 2'h0;
      end else if (do_write) begin
         if (wr_rg == RG_DRAIN) drain_q <= drain_wr[19:0];
         if (wr_rg == RG_FILL) fill_q <= fill_wr[19:0];
         if (wr_rg == RG_MASK && wstrb_q[0]) mask_q <= wdata_q[1:0];
      end
   end

   // flush takes the read pointer even if a frame completes in the same cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_wr_q <= 4'h0;
         rx_last_q <= 4'h0;
      end else if (flush) begin
         rx_wr_q <= rx_rd_ptr_i;
      end else if (rx_done_i) begin
         rx_last_q <= rx_wr_q;
         rx_wr_q <= 4'((32'(rx_wr_q) + 1) % RX_SLOTS);
      end
   end

   // =====================================================================
   // interrupt status: sticky, set beats clear
   assign stat_set[PBSC_IRQ_TX] = st_q == TX_STAMP;
   assign stat_set[PBSC_IRQ_RX] = rx_done_i;
   assign stat_clr[PBSC_IRQ_TX] = (do_read && (rd_rg == RG_TXC || rd_rg == RG_STAT))
                                || (do_write && wr_rg == RG_TXC);
   assign stat_clr[PBSC_IRQ_RX] = (do_read && (rd_rg == RG_RXC || rd_rg == RG_STAT))
                                || (do_write && wr_rg == RG_RXC);
   assign stat_d = (stat_q & ~stat_clr) | stat_set;
   assign irq_o = |(stat_q & mask_q);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) stat_q <= 2'h0;
      else stat_q <= stat_d;
   end

   // =====================================================================
   // checks
   logic [7:0] sent_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) sent_q <= 8'h0;
      else if (grant) sent_q <= 8'h0;
      else if (tx_hs) sent_q <= sent_q + 8'h01;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_req_sets_pend: assert property (do_write && wr_rg == RG_TXC && wstrb_q[0]
      |=> (pend_q & $past(wdata_q[7:0])) == $past(wdata_q[7:0]))
      else $error("request bit did not set pending");
   a_pend_held_send: assert property (st_q == TX_SEND |-> pend_q[slot_q])
      else $error("pending dropped during send");
   a_stamp_ends_pend: assert property (st_q == TX_STAMP
      |=> !pend_q[$past(slot_q)] && tx_last_q == $past(slot_q))
      else $error("pending or last slot wrong after send");
   a_stamp_written: assert property (st_q == TX_STAMP
      |=> mem_q[{$past(slot_q), PBSC_STAMP_WORD}] == $past(tx_stamp_i))
      else $error("timestamp not written back");
   a_exact_length: assert property (st_q == TX_STAMP |-> sent_q == len_q)
      else $error("sent byte count differs from length byte");
   a_grant_credit: assert property (st_q == TX_SEND && $past(st_q) == TX_IDLE
      |-> !$past(credit_q[31]))
      else $error("grant while credit negative");
   a_drain_rate: assert property (st_q == TX_SEND
      |=> credit_q == $past(credit_q) - signed'(32'($past(drain_q))))
      else $error("credit did not drain by drain rate");
   a_tx_irq_set: assert property (st_q == TX_STAMP |=> stat_q[PBSC_IRQ_TX])
      else $error("transmit done flag not set");
   a_rx_advance: assert property (rx_done_i && !flush
      |=> rx_wr_q == 4'($past(rx_wr_q) + 4'h1) && rx_last_q == $past(rx_wr_q) && stat_q[1])
      else $error("receive pointer or flag wrong");
   a_rx_flush: assert property (flush |=> rx_wr_q == $past(rx_rd_ptr_i))
      else $error("flush did not take read pointer");

   c_frame_sent: cover property (st_q == TX_SEND ##[1:300] st_q == TX_STAMP);
   c_rx_flush: cover property (flush);
   c_aw_w_split: cover property (aw_held_q && !w_held_q ##1 w_held_q);
   c_shaper_wait: cover property (any_pend && st_q == TX_IDLE && credit_q[31]);
endmodule

//--- pbsc_mac_model.sv
// Purpose: behavioural MAC transmit sink facing the PTP slot sender
// Assumes: same clock as the register bank; one byte per accepted beat
// Notes: stalls every other cycle when slow_i is high; stamp steps once per frame
`timescale 1ns/1ps
module pbsc_mac_model #(
   parameter logic [31:0] STAMP_BASE = 32'h7e570000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   input wire logic tx_last_i,
   output logic tx_ready_o,
   output logic [31:0] tx_stamp_o
);
   // =====================================================================
   // acceptance and capture
   logic tog_q;
   logic [7:0] q[$];
   int frames;
   // a slow sink stalls the sender mid-frame, which a prompt one never does
   assign tx_ready_o = !slow_i || tog_q;
   // stamp steps at the edge that takes the last byte, so the cycle after it sees the new value
   assign tx_stamp_o = STAMP_BASE + 32'(frames);
   // every accepted byte is kept so the bench can check count and order
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tog_q <= 1'b0;
         frames <= 0;
         q.delete();
      end else begin
         tog_q <= !tog_q;
         if (tx_valid_i && tx_ready_o) begin
            q.push_back(tx_data_i);
            if (tx_last_i) frames <= frames + 1;
         end
      end
   end
endmodule

//--- tb_top.sv
// Purpose: self-checking bench for the PTP buffer and shaper control block
// Assumes: AXI4-Lite master tasks, MAC sink model on the transmit stream
// Notes: random data from a fixed-seed xorshift; slopes restored before sending
`timescale 1ns/1ps
module tb_top import pbsc_pkg::*; ;
   localparam logic [31:0] STAMP = 32'h7e570000; // arbitrary stamp base
   logic clk_i, rst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic tx_valid_o, tx_last_o, tx_ready_i, rx_done_i, irq_o, slow;
   logic [17:0] s_axi_awaddr, s_axi_araddr, a;
   logic [31:0] s_axi_wdata, s_axi_rdata, tx_stamp_i, rd, d2, d3, v, seed;
   logic [3:0] s_axi_wstrb, rx_rd_ptr_i, rx_wr_ptr_o;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] tx_data_o;
   int mismatches, checked, n;
   pbsc_ctrl dut (.clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .tx_data_o, .tx_valid_o, .tx_last_o, .tx_ready_i, .tx_stamp_i, .rx_done_i,
      .rx_rd_ptr_i, .rx_wr_ptr_o, .irq_o);
   pbsc_mac_model #(.STAMP_BASE(STAMP)) mdl (.clk_i, .rst_i, .slow_i(slow), .tx_data_i(tx_data_o),
      .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i),
      .tx_stamp_o(tx_stamp_i));
   // =====================================================================
   // helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [17:0] sa(input int s, input int w);
      return PBSC_TX_MEM_BASE + 18'(s * 256 + w * 4);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // =====================================================================
   // bus tasks: each channel released at the edge it is taken
   task automatic axw(input logic [17:0] ad, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
      logic aw_t, w_t, b_t;
      @(posedge clk_i);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // handshakes are judged on settled values before the edge that takes them
      for (n = 0; n < 100; n++) begin
         @(negedge clk_i);
         aw_t = s_axi_awvalid && s_axi_awready === 1'b1;
         w_t = s_axi_wvalid && s_axi_wready === 1'b1;
         b_t = s_axi_bvalid === 1'b1;
         @(posedge clk_i);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
         if (b_t) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 100) mismatches++;
      chk(32'(s_axi_bresp), 32'(r));
   endtask
   task automatic axr(input logic [17:0] ad, input logic [1:0] r);
      logic ar_t, r_t;
      @(posedge clk_i);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(negedge clk_i);
         ar_t = s_axi_arvalid && s_axi_arready === 1'b1;
         r_t = s_axi_rvalid === 1'b1;
         rd = s_axi_rdata;
         @(posedge clk_i);
         if (ar_t) s_axi_arvalid <= 1'b0;
         if (r_t) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 100) mismatches++;
      chk(32'(s_axi_rresp), 32'(r));
   endtask
   task automatic rck(input logic [17:0] ad, input logic [31:0] e);
      axr(ad, PBSC_RESP_OKAY);
      chk(rd, e);
   endtask
   task automatic rxp();
      @(posedge clk_i);
      rx_done_i <= 1'b1;
      @(posedge clk_i);
      rx_done_i <= 1'b0;
   endtask
   // =====================================================================
   // clock, watchdog and main sequence
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // a hang anywhere ends the run through the normal verdict
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      give_verdict();
   end
   initial begin
      seed = 32'h5a7c;
      rst_i = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {rx_done_i, slow, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      rx_rd_ptr_i = 4'h0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rck(sa(i, 0), (i < 7) ? 32'h44 : 32'h0);
         rck(sa(i, 5), (i < 7) ? {8'h02, PBSC_MSG_TYPE[i % 7], PBSC_PRE_ETYPE} : 32'h0);
      end
      rck(PBSC_REG_DRAIN, 32'h800);
      rck(PBSC_REG_FILL, 32'h1800);
      rck(PBSC_REG_TX_CTRL, 32'h0);
      rck(PBSC_REG_RX_CTRL, 32'h0);
      axr(18'h12008, PBSC_RESP_SLVERR);
      chk(rd, 32'h0);
      axw(18'h12014, xs(), 4'hf, PBSC_RESP_SLVERR);
      $display("test reset and map done");
      for (int i = 0; i < 6; i++) begin
         v = xs();
         axw(PBSC_REG_DRAIN, v, 4'hf, PBSC_RESP_OKAY);
         axw(PBSC_REG_FILL, ~v, 4'hf, PBSC_RESP_OKAY);
         rck(PBSC_REG_DRAIN, v & 32'hfffff);
         rck(PBSC_REG_FILL, ~v & 32'hfffff);
         a = sa(4 + int'(v[1:0]), 1 + int'(v[7:2]) % 61);
         axw(a, v ^ 32'h9e3779b9, 4'hf, PBSC_RESP_OKAY);
         rck(a, v ^ 32'h9e3779b9);
      end
      axw(sa(6, 60), 32'hffffffff, 4'hf, PBSC_RESP_OKAY);
      axw(sa(6, 60), 32'h0, 4'h5, PBSC_RESP_OKAY);
      rck(sa(6, 60), 32'hff00ff00);
      // default slopes keep the second frame's credit wait short
      axw(PBSC_REG_DRAIN, 32'h800, 4'hf, PBSC_RESP_OKAY);
      axw(PBSC_REG_FILL, 32'h1800, 4'hf, PBSC_RESP_OKAY);
      $display("test slopes and memory done");
      axw(PBSC_REG_IRQ_MASK, 32'h3, 4'hf, PBSC_RESP_OKAY);
      d2 = xs();
      d3 = xs();
      axw(sa(7, 0), 32'h5, 4'h1, PBSC_RESP_OKAY);
      axw(sa(7, 2), d2, 4'hf, PBSC_RESP_OKAY);
      axw(sa(7, 3), d3, 4'hf, PBSC_RESP_OKAY);
      slow <= 1'b1;
      axw(PBSC_REG_TX_CTRL, 32'h88, 4'h1, PBSC_RESP_OKAY);
      axr(PBSC_REG_TX_CTRL, PBSC_RESP_OKAY);
      chk(rd & 32'hffff, 32'h8800);
      for (n = 0; n < 3000 && mdl.frames < 2; n++) @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      chk(32'(mdl.q.size()), 32'd73);
      chk({mdl.q[0], mdl.q[14]}, 32'h0103);
      chk({mdl.q[68], mdl.q[71], mdl.q[72]}, {d2[7:0], d2[31:24], d3[7:0]});
      chk(32'(irq_o), 32'h1);
      rck(PBSC_REG_TX_CTRL, 32'h70000);
      chk(32'(irq_o), 32'h0);
      rck(sa(3, 63), STAMP + 32'h1);
      rck(sa(7, 63), STAMP + 32'h2);
      $display("test transmit done");
      rx_rd_ptr_i <= 4'(xs());
      repeat (3) rxp();
      @(negedge clk_i);
      chk(32'(rx_wr_ptr_o), 32'h3);
      chk(32'(irq_o), 32'h1);
      rck(PBSC_REG_RX_CTRL, 32'h200);
      chk(32'(irq_o), 32'h0);
      axw(PBSC_REG_RX_CTRL, 32'h1, 4'h1, PBSC_RESP_OKAY);
      chk(32'(rx_wr_ptr_o), 32'(rx_rd_ptr_i));
      rxp();
      rck(PBSC_REG_IRQ_STAT, 32'h2);
      rck(PBSC_REG_IRQ_STAT, 32'h0);
      axw(PBSC_REG_IRQ_MASK, 32'h0, 4'hf, PBSC_RESP_OKAY);
      rxp();
      @(negedge clk_i);
      chk(32'(irq_o), 32'h0);
      $display("test receive and interrupt done");
      give_verdict();
   end
endmodule
